// file: design/slc_selfprog_lock_control.sv
// slc_selfprog_lock_control: lock checking, control/status register, axi4-lite slave
`include "slc_map.svh"

module slc_selfprog_lock_control
(
    // clock and reset
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    // axi4-lite write channels
    input  wire logic [7:0]           awaddr,
    input  wire logic                 awvalid,
    output logic                      awready,
    input  wire logic [31:0]          wdata,
    input  wire logic [3:0]           wstrb,
    input  wire logic                 wvalid,
    output logic                      wready,
    output logic [1:0]                bresp,
    output logic                      bvalid,
    input  wire logic                 bready,
    // axi4-lite read channels
    input  wire logic [7:0]           araddr,
    input  wire logic                 arvalid,
    output logic                      arready,
    output logic [31:0]               rdata,
    output logic [1:0]                rresp,
    output logic                      rvalid,
    input  wire logic                 rready,
    // core requests
    input  wire logic                 spm_valid,
    input  wire slc_pkg::slc_spm_s    store_program_instr,
    input  wire logic                 lpm_valid,
    input  wire slc_pkg::slc_lpm_s    lpm,
    input  wire slc_pkg::slc_addr_t   exec_pc,
    input  wire logic                 gie,
    input  wire logic                 ivec_in_loader,
    input  wire logic [7:0]           flash_rdata,
    // flash engine and nonvolatile state
    input  wire logic                 flash_busy,
    input  wire logic                 page_op_start,
    input  wire slc_pkg::slc_addr_t   page_op_addr,
    input  wire logic                 chip_erase,
    input  wire logic [7:0]           fuse_low,
    input  wire logic                 boot_reset_select,
    input  wire slc_pkg::slc_addr_t   loader_base,
    input  wire slc_pkg::slc_addr_t   live_limit,
    // answers to core and flash
    output logic                      spm_done,
    output logic                      spm_denied,
    output logic                      load_strobe,
    output logic                      load_abort,
    output logic                      page_op_denied,
    output logic                      live_busy,
    output logic                      lpm_done,
    output logic                      lpm_denied,
    output logic [7:0]                lpm_data,
    output logic                      ready_irq,
    output logic                      irq_block,
    output slc_pkg::slc_addr_t        reset_vector,
    output logic [7:0]                lock_bits
);

    // ======================================================================
    // helpers
    function automatic logic in_ldr(input slc_pkg::slc_addr_t a,
                                    input slc_pkg::slc_addr_t base);
        return a >= base;
    endfunction

    function automatic slc_pkg::slc_cmd_e cmd_of(input logic [4:0] c);
        if (c == `SLC_CODE_REEN)
            return slc_pkg::CMD_REEN;
        else if (c == `SLC_CODE_LSET)
            return slc_pkg::CMD_LSET;
        else if (c == `SLC_CODE_PGW)
            return slc_pkg::CMD_PGW;
        else if (c == `SLC_CODE_PGE)
            return slc_pkg::CMD_PGE;
        else
            return slc_pkg::CMD_LOAD;
    endfunction

    // ======================================================================
    // state
    logic                 aw_got_r;
    logic                 w_got_r;
    logic [7:0]           awaddr_r;
    logic [7:0]           wdata_r;
    logic                 wstrb0_r;
    logic                 ie_r;
    logic                 busy_r;
    logic                 arm_r;
    logic [2:0]           cnt_r;
    slc_pkg::slc_cmd_e    cmd_r;
    logic                 loading_r;
    logic [7:0]           lock_r;

    // ======================================================================
    // bus decode
    wire        aw_hs   = awvalid & awready;
    wire        w_hs    = wvalid & wready;
    wire        ar_hs   = arvalid & arready;
    wire        wr_go   = aw_got_r & w_got_r;
    wire        aw_nxt  = aw_hs | (aw_got_r & ~wr_go);
    wire        w_nxt   = w_hs | (w_got_r & ~wr_go);
    wire        bv_nxt  = wr_go | (bvalid & ~bready);
    wire        rv_nxt  = ar_hs | (rvalid & ~rready);
    wire        wr_map  = awaddr_r == `SLC_OFS_CTRL || awaddr_r == `SLC_OFS_LOCK
                          || awaddr_r == `SLC_OFS_FUSE;
    wire        ctrl_wr = wr_go && awaddr_r == `SLC_OFS_CTRL && wstrb0_r;
    wire [4:0]  code    = wdata_r[4:0];
    wire        legal   = code inside {`SLC_CODE_REEN, `SLC_CODE_LSET, `SLC_CODE_PGW,
                                       `SLC_CODE_PGE, `SLC_CODE_LOAD};
    wire        arm_wr  = ctrl_wr && legal && !flash_busy;
    wire        reen_wr = arm_wr && cmd_of(code) == slc_pkg::CMD_REEN;

    // ======================================================================
    // store-program and section decode
    wire spm_ldr   = in_ldr(store_program_instr.pc, loader_base);
    wire spm_take  = spm_valid && arm_r && cnt_r != 3'h0 && spm_ldr;
    wire arm_nxt   = arm_wr | flash_busy | (arm_r & (cnt_r > 3'h1) & ~spm_take);
    wire take_reen = spm_take && cmd_r == slc_pkg::CMD_REEN && !flash_busy;
    wire take_load = spm_take && cmd_r == slc_pkg::CMD_LOAD;
    wire take_lset = spm_take && cmd_r == slc_pkg::CMD_LSET;
    wire op_ldr    = in_ldr(page_op_addr, loader_base);
    // memory lock bits 1:0 never enter these
    wire op_deny   = (!op_ldr && !lock_r[`SLC_L_APP_WL])
                     || (op_ldr && !lock_r[`SLC_L_LDR_WL]);
    wire busy_set  = page_op_start && !op_deny && page_op_addr < live_limit;
    wire busy_clr  = take_reen | take_load;

    // ======================================================================
    // load-program decode
    wire lpm_src_ldr = in_ldr(lpm.pc, loader_base);
    wire lpm_dst_ldr = in_ldr(lpm.z, loader_base);
    wire rb_win      = arm_r && cmd_r == slc_pkg::CMD_LSET
                       && cnt_r > (`SLC_ARM_CLOCKS - `SLC_RB_CLOCKS);
    wire lpm_deny    = (lpm_src_ldr && !lpm_dst_ldr && !lock_r[`SLC_L_APP_RL])
                       || (!lpm_src_ldr && lpm_dst_ldr && !lock_r[`SLC_L_LDR_RL])
                       || (busy_r && lpm.z < live_limit);
    wire [7:0] lpm_nxt = rb_win ? (lpm.z[0] ? fuse_low : lock_r)
                         : (lpm_deny ? 8'h00 : flash_rdata);
    wire pc_ldr  = in_ldr(exec_pc, loader_base);
    wire blk_nxt = (!lock_r[`SLC_L_APP_RL] && ivec_in_loader && !pc_ldr)
                   || (!lock_r[`SLC_L_LDR_RL] && !ivec_in_loader && pc_ldr);

    // ======================================================================
    // read mux
    logic [7:0] ctrl_rd;
    logic [7:0] rd_nxt;
    logic       rd_err;

    always_comb
    begin
        ctrl_rd = `SLC_CTRL_RST;
        ctrl_rd[`SLC_B_IE]   = ie_r;
        ctrl_rd[`SLC_B_BUSY] = busy_r;
        ctrl_rd[`SLC_B_RES]  = 1'b0;
        ctrl_rd[`SLC_B_REEN] = cmd_r == slc_pkg::CMD_REEN;
        ctrl_rd[`SLC_B_LSET] = cmd_r == slc_pkg::CMD_LSET;
        ctrl_rd[`SLC_B_PGW]  = cmd_r == slc_pkg::CMD_PGW;
        ctrl_rd[`SLC_B_PGE]  = cmd_r == slc_pkg::CMD_PGE;
        ctrl_rd[`SLC_B_ARM]  = arm_r;
        rd_err = 1'b0;
        if (araddr == `SLC_OFS_CTRL)
            rd_nxt = ctrl_rd;
        else if (araddr == `SLC_OFS_LOCK)
            rd_nxt = lock_r;
        else if (araddr == `SLC_OFS_FUSE)
            rd_nxt = fuse_low;
        else
        begin
            rd_nxt = 8'h00;
            rd_err = 1'b1;
        end
    end

    // ======================================================================
    // axi4-lite slave
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            awready  <= 1'b0;
            wready   <= 1'b0;
            bvalid   <= 1'b0;
            arready  <= 1'b0;
            rvalid   <= 1'b0;
        end
        else
        begin
            aw_got_r <= aw_nxt;
            w_got_r  <= w_nxt;
            awready  <= ~aw_nxt & ~bv_nxt;
            wready   <= ~w_nxt & ~bv_nxt;
            bvalid   <= bv_nxt;
            arready  <= ~rv_nxt;
            rvalid   <= rv_nxt;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awaddr_r <= 8'h00;
            wdata_r  <= 8'h00;
            wstrb0_r <= 1'b0;
            bresp    <= `SLC_RESP_OKAY;
            rdata    <= 32'h0000_0000;
            rresp    <= `SLC_RESP_OKAY;
        end
        else
        begin
            if (aw_hs)
                awaddr_r <= awaddr;
            if (w_hs)
            begin
                wdata_r  <= wdata[7:0];
                wstrb0_r <= wstrb[0];
            end
            if (wr_go)
                bresp <= wr_map ? `SLC_RESP_OKAY : `SLC_RESP_SLVERR;
            if (ar_hs)
            begin
                rdata <= {24'h00_0000, rd_nxt};
                rresp <= rd_err ? `SLC_RESP_SLVERR : `SLC_RESP_OKAY;
            end
        end
    end

    // ======================================================================
    // control/status and arming window
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ie_r  <= 1'b0;
            arm_r <= 1'b0;
            cnt_r <= 3'h0;
            cmd_r <= slc_pkg::CMD_NONE;
        end
        else
        begin
            if (ctrl_wr)
                ie_r <= wdata_r[`SLC_B_IE];
            arm_r <= arm_nxt;
            if (arm_wr)
                cnt_r <= `SLC_ARM_CLOCKS;
            else if (spm_take)
                cnt_r <= 3'h0;
            else if (cnt_r != 3'h0)
                cnt_r <= cnt_r - 3'h1;
            if (arm_wr)
                cmd_r <= cmd_of(code);
            else if (!arm_nxt)
                cmd_r <= slc_pkg::CMD_NONE;
        end
    end

    // ======================================================================
    // busy flag, page loading, lock bits
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            busy_r    <= 1'b0;
            loading_r <= 1'b0;
        end
        else
        begin
            busy_r    <= busy_set | (busy_r & ~busy_clr);
            loading_r <= take_load | (loading_r & ~reen_wr & ~page_op_start);
        end
    end

    // nonvolatile lock bits: system reset leaves them alone
    always_ff @(posedge aclk)
    begin
        if (chip_erase)
            lock_r <= `SLC_LOCK_RST;
        else if (take_lset)
            lock_r <= lock_r & store_program_instr.r0;
    end

    // ======================================================================
    // registered answers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            spm_done       <= 1'b0;
            spm_denied     <= 1'b0;
            load_strobe    <= 1'b0;
            load_abort     <= 1'b0;
            page_op_denied <= 1'b0;
            lpm_done       <= 1'b0;
            lpm_denied     <= 1'b0;
            lpm_data       <= 8'h00;
            ready_irq      <= 1'b0;
            irq_block      <= 1'b0;
            reset_vector   <= `SLC_APP_RESET;
        end
        else
        begin
            spm_done       <= spm_take;
            spm_denied     <= spm_valid & ~spm_take;
            load_strobe    <= take_load;
            load_abort     <= reen_wr & loading_r;
            page_op_denied <= page_op_start & op_deny;
            lpm_done       <= lpm_valid;
            lpm_denied     <= lpm_valid & ~rb_win & lpm_deny;
            if (lpm_valid)
                lpm_data <= lpm_nxt;
            ready_irq      <= ie_r & gie & ~arm_r;
            irq_block      <= blk_nxt;
            reset_vector   <= boot_reset_select ? `SLC_APP_RESET : loader_base;
        end
    end

    assign live_busy = busy_r;
    assign lock_bits = lock_r;

    // ======================================================================
    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_lock_program_only;
        !chip_erase |=> (lock_r & ~$past(lock_r)) == 8'h00;
    endproperty
    a_lock_program_only: assert property (p_lock_program_only)
        else $error("lock bit returned to unprogrammed without erase");

    property p_app_write_block;
        page_op_start && !op_ldr && !lock_r[`SLC_L_APP_WL] |=> page_op_denied && !busy_r;
    endproperty
    a_app_write_block: assert property (p_app_write_block)
        else $error("page op into locked application section not denied");

    property p_ldr_write_block;
        page_op_start && op_ldr && !lock_r[`SLC_L_LDR_WL] |=> page_op_denied;
    endproperty
    a_ldr_write_block: assert property (p_ldr_write_block)
        else $error("page op into locked loader section not denied");

    property p_app_read_block;
        lpm_valid && !rb_win && lpm_src_ldr && !lpm_dst_ldr && !lock_r[`SLC_L_APP_RL]
            |=> lpm_denied && lpm_data == 8'h00;
    endproperty
    a_app_read_block: assert property (p_app_read_block)
        else $error("loader read of locked application section allowed");

    property p_ldr_read_block;
        lpm_valid && !rb_win && !lpm_src_ldr && lpm_dst_ldr && !lock_r[`SLC_L_LDR_RL]
            |=> lpm_denied;
    endproperty
    a_ldr_read_block: assert property (p_ldr_read_block)
        else $error("application read of locked loader section allowed");

    property p_reset_vector;
        aresetn |=> reset_vector == ($past(boot_reset_select) ? `SLC_APP_RESET
                                                              : $past(loader_base));
    endproperty
    a_reset_vector: assert property (p_reset_vector)
        else $error("reset vector does not follow boot reset select");

    property p_ready_irq;
        ie_r && gie && !arm_r |=> ready_irq;
    endproperty
    a_ready_irq: assert property (p_ready_irq)
        else $error("ready interrupt not requested while idle and enabled");

    property p_arm_expire;
        arm_wr ##1 (!flash_busy && !spm_valid) [*4] |=> !arm_r && cmd_r == slc_pkg::CMD_NONE;
    endproperty
    a_arm_expire: assert property (p_arm_expire)
        else $error("arm window did not close after four clocks");

    property p_busy_set;
        busy_set |=> busy_r && live_busy;
    endproperty
    a_busy_set: assert property (p_busy_set)
        else $error("live section busy not set by page op");

    property p_reserved_zero;
        ar_hs && araddr == `SLC_OFS_CTRL |=> rvalid && rdata[`SLC_B_RES] == 1'b0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved control bit read as one");

    property p_app_spm_ignored;
        spm_valid && !spm_ldr |=> spm_denied && !spm_done && $stable(lock_r);
    endproperty
    a_app_spm_ignored: assert property (p_app_spm_ignored)
        else $error("store-program from application section took effect");

endmodule // slc_selfprog_lock_control

// file: pkg/slc_map.svh
// slc_map.svh: offsets, field positions, reset values and timing counts
`ifndef SLC_MAP_SVH
`define SLC_MAP_SVH
// ==========================================================================
// register byte offsets
`define SLC_OFS_CTRL    8'h00
`define SLC_OFS_LOCK    8'h04
`define SLC_OFS_FUSE    8'h08
// ==========================================================================
// control/status fields
`define SLC_B_IE        7
`define SLC_B_BUSY      6
`define SLC_B_RES       5
`define SLC_B_REEN      4
`define SLC_B_LSET      3
`define SLC_B_PGW       2
`define SLC_B_PGE       1
`define SLC_B_ARM       0
`define SLC_CTRL_RST    8'h00
// legal low five bit patterns of a control write
`define SLC_CODE_REEN   5'h11
`define SLC_CODE_LSET   5'h09
`define SLC_CODE_PGW    5'h05
`define SLC_CODE_PGE    5'h03
`define SLC_CODE_LOAD   5'h01
// ==========================================================================
// lock byte fields, 1 = unprogrammed
`define SLC_L_APP_WL    2
`define SLC_L_APP_RL    3
`define SLC_L_LDR_WL    4
`define SLC_L_LDR_RL    5
`define SLC_LOCK_RST    8'hFF
// ==========================================================================
// timing in clocks, reset vector, bus answers
`define SLC_ARM_CLOCKS  3'h4
`define SLC_RB_CLOCKS   3'h3
`define SLC_APP_RESET   16'h0000
`define SLC_RESP_OKAY   2'h0
`define SLC_RESP_SLVERR 2'h2
`endif

// file: pkg/slc_pkg.sv
// slc_pkg: types shared by the self-programming lock control block
package slc_pkg;
    typedef logic [15:0] slc_addr_t;

    // armed store-program meaning
    typedef enum logic [2:0] {
        CMD_NONE,
        CMD_LOAD,
        CMD_PGE,
        CMD_PGW,
        CMD_LSET,
        CMD_REEN
    } slc_cmd_e;

    // store-program request from the core
    typedef struct packed {
        slc_addr_t   pc;
        slc_addr_t   z;
        logic [7:0]  r0;
    } slc_spm_s;

    // load-program request from the core
    typedef struct packed {
        slc_addr_t   pc;
        slc_addr_t   z;
    } slc_lpm_s;
endpackage

// file: test/slc_core_model.sv
// slc_core_model: behavioural cpu core issuing store and load program instructions
module slc_core_model
(
    // clock
    input  wire logic          aclk,
    // instruction requests
    output logic               spm_valid,
    output slc_pkg::slc_spm_s  store_program_instr,
    output logic               lpm_valid,
    output slc_pkg::slc_lpm_s  lpm,
    output slc_pkg::slc_addr_t exec_pc
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        spm_valid = 1'b0;
        lpm_valid = 1'b0;
        store_program_instr       = '0;
        lpm       = '0;
        exec_pc   = 16'h0000;
    end
    // ======================================================================
    // instruction tasks, entered just after a rising edge
    task automatic at(input slc_pkg::slc_addr_t pc);
        exec_pc <= pc;
    endtask
    // store issued for one clock, whether or not software opened an arm window
    task automatic store(input slc_pkg::slc_addr_t pc, input logic [7:0] r0);
        exec_pc   <= pc;
        spm_valid <= 1'b1;
        store_program_instr       <= '{pc: pc, z: 16'h0000, r0: r0};
        @(posedge aclk);
        spm_valid <= 1'b0;
        store_program_instr       <= slc_pkg::slc_spm_s'(~store_program_instr);
    endtask
    task automatic load(input slc_pkg::slc_addr_t pc, input slc_pkg::slc_addr_t z);
        exec_pc   <= pc;
        lpm_valid <= 1'b1;
        lpm       <= '{pc: pc, z: z};
        @(posedge aclk);
        lpm_valid <= 1'b0;
        lpm       <= slc_pkg::slc_lpm_s'(~lpm);
    endtask
endmodule // slc_core_model

// file: test/slc_selfprog_lock_control_test.sv
// slc_selfprog_lock_control_test: self-checking bench with integer reference model
module slc_selfprog_lock_control_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] APP = 16'h0100;
    localparam logic [15:0] LDR = 16'h3900;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
    logic rready = 0, gie = 0, ivl = 0, fbusy = 0, pstart = 0, cerase = 1, bsel = 1;
    logic [7:0]  awaddr = 0, araddr = 0, fuse = 0, frd = 0;
    logic [31:0] wdata = 0, rdata;
    logic [15:0] paddr = 0;
    logic [1:0]  bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid, spm_v, lpm_v, done, sden, lstb, labt;
    logic pden, lbusy, ldone, lden, rirq, iblk;
    logic [7:0]  ldata, lbits;
    logic [15:0] rvec, pc;
    slc_pkg::slc_spm_s store_program_instr;
    slc_pkg::slc_lpm_s lpm;
    int bad_count = 0, total_checks = 0, cycles = 0, aborts = 0, m_lock = 255, n;
    int r0q[$];
    always #50 aclk = ~aclk;
    always @(posedge aclk)
    begin
        cycles++;
        if (labt === 1'b1) aborts++;
        if (cycles == 20000)
        begin
            bad_count++;
            summarize();
        end
    end
    slc_core_model core (.aclk(aclk), .spm_valid(spm_v), .store_program_instr(store_program_instr), .lpm_valid(lpm_v),
        .lpm(lpm), .exec_pc(pc));
    slc_selfprog_lock_control uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'h1), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .spm_valid(spm_v), .store_program_instr(store_program_instr), .lpm_valid(lpm_v), .lpm(lpm),
        .exec_pc(pc), .gie(gie), .ivec_in_loader(ivl), .flash_rdata(frd),
        .flash_busy(fbusy), .page_op_start(pstart), .page_op_addr(paddr),
        .chip_erase(cerase), .fuse_low(fuse), .boot_reset_select(bsel),
        .loader_base(16'h3800), .live_limit(16'h3800), .spm_done(done), .spm_denied(sden),
        .load_strobe(lstb), .load_abort(labt), .page_op_denied(pden), .live_busy(lbusy),
        .lpm_done(ldone), .lpm_denied(lden), .lpm_data(ldata), .ready_irq(rirq),
        .irq_block(iblk), .reset_vector(rvec), .lock_bits(lbits));
    // ======================================================================
    // checks and bus tasks
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk(bresp, er);
    endtask
    task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        chk(rresp, er);
        chk(rdata, exp);
    endtask
    task automatic page(input logic [15:0] a);
        paddr  <= a;
        pstart <= 1'b1;
        @(posedge aclk);
        pstart <= 1'b0;
        #1;
    endtask
    task automatic rst();
        aresetn <= 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        #1;
    endtask
    // ======================================================================
    // main sequence
    initial
    begin
        void'($urandom(63889));
        fuse = 8'($urandom);
        frd  = 8'($urandom);
        rst();
        cerase <= 1'b0;
        chk(rvec, 16'h0000);
        chk_reg(8'h00, 0, 0);
        chk_reg(8'h08, fuse, 0);
        chk_reg(8'h0C, 0, 2);
        wr(8'h0C, 1, 2);
        wr(8'h04, 0, 0);
        wr(8'h08, 0, 0);
        chk_reg(8'h04, m_lock, 0);
        chk_reg(8'h08, fuse, 0);
        r0q.push_back(($urandom & 8'hC3) | 8'h30);
        r0q.push_back(8'hCF);
        for (int i = 0; i < 2; i++)
        begin
            wr(8'h00, 32'h0000_0009, 0);
            core.load(LDR, 16'(1 - i)); #1;
            chk(ldata, i ? m_lock : fuse);
            chk(ldone, 1);
            core.store(LDR, 8'(r0q[0])); #1;
            m_lock &= r0q.pop_front();
            chk(done, 1);
            chk(lbits, m_lock);
            chk_reg(8'h00, 0, 0);
            page(i ? LDR : APP);
            chk(pden, 1);
            core.load(i ? APP : LDR, i ? LDR : APP); #1;
            chk(lden, 1);
            ivl <= !i;
            core.at(i ? LDR : APP);
            repeat (2) @(posedge aclk); #1;
            chk(iblk, 1);
            if (i == 0)
            begin
                page(LDR);
                chk(pden, 0);
                core.load(APP, APP); #1;
                chk(lden, 0);
                chk(ldata, frd);
            end
        end
        wr(8'h00, 32'h0000_0009, 0);
        core.store(LDR, 8'hFF); #1;
        chk(lbits, m_lock);
        cerase <= 1'b1;
        @(posedge aclk);
        cerase <= 1'b0;
        repeat (2) @(posedge aclk);
        m_lock = 255;
        chk(lbits, m_lock);
        wr(8'h00, 32'h0000_0001, 0);
        repeat (6) @(posedge aclk);
        core.store(LDR, 0); #1;
        chk(sden, 1);
        chk_reg(8'h00, 0, 0);
        wr(8'h00, 32'h0000_0001, 0);
        core.store(APP, 0); #1;
        chk(sden, 1);
        gie <= 1'b1;
        wr(8'h00, 32'h0000_0080, 0);
        chk_reg(8'h00, 32'h0000_0080, 0);
        chk(rirq, 1);
        wr(8'h00, 32'h0000_0081, 0); #1;
        chk(rirq, 0);
        repeat (6) @(posedge aclk); #1;
        chk(rirq, 1);
        page(APP);
        chk(lbusy, 1);
        chk_reg(8'h00, 32'h0000_00C0, 0);
        core.load(LDR, APP); #1;
        chk(lden, 1);
        fbusy <= 1'b1;
        wr(8'h00, 32'h0000_0011, 0);
        core.store(LDR, 0); #1;
        chk(lbusy, 1);
        fbusy <= 1'b0;
        wr(8'h00, 32'h0000_0011, 0);
        core.store(LDR, 0); #1;
        chk(done, 1);
        chk(lbusy, 0);
        page(APP);
        wr(8'h00, 32'h0000_0001, 0);
        core.store(LDR, 0); #1;
        chk(lstb, 1);
        chk(lbusy, 0);
        n = aborts;
        wr(8'h00, 32'h0000_0011, 0);
        core.store(LDR, 0);
        repeat (2) @(posedge aclk);
        chk(aborts, n + 1);
        wr(8'h00, 32'h0000_0009, 0);
        core.store(LDR, 8'hFB); #1;
        m_lock &= 8'hFB;
        bsel <= 1'b0;
        rst();
        chk(rvec, 16'h3800);
        chk(lbits, m_lock);
        summarize();
    end
endmodule // slc_selfprog_lock_control_test
